/* File: rtl/dpsf_pkg.sv */
// Package with the register map, field positions and codes of the debug port status block
package dpsf_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam int DPSF_AW = 4;
    localparam logic [3:0] DPSF_OFS_STATUS = 4'h0;
    localparam logic [3:0] DPSF_OFS_IRQ_STAT = 4'h4;
    localparam logic [3:0] DPSF_OFS_IRQ_MASK = 4'h8;
    localparam logic [31:0] DPSF_RST_WORD = 32'h0000_0000;
    localparam logic [3:0] DPSF_RST_IRQ = 4'h0;

    // ****************************************
    // Status word bit positions
    // ****************************************
    localparam int DPSF_B_ERASE_ACK = 0;
    localparam int DPSF_B_FLASH_RDY = 1;
    localparam int DPSF_B_SECURE = 2;
    localparam int DPSF_B_SYS_OUT_RST = 3;
    localparam int DPSF_B_RSVD = 4;
    localparam int DPSF_B_ERASE_EN = 5;
    localparam int DPSF_B_BACKDOOR = 6;
    localparam int DPSF_B_LP_STOP = 7;
    localparam int DPSF_B_VLP_MODE = 8;

    // ****************************************
    // Interrupt event bits
    // ****************************************
    localparam int DPSF_I_ACK = 0;
    localparam int DPSF_I_READY = 1;
    localparam int DPSF_I_SECURE = 2;
    localparam int DPSF_I_VLP = 3;

    // ****************************************
    // Stop mode select codes
    // ****************************************
    localparam logic [2:0] DPSF_STOP_VERY_LOW_POWER_STOP = 3'h2;
    localparam logic [2:0] DPSF_STOP_LLS = 3'h3;
    localparam logic [2:0] DPSF_STOP_VLLS = 3'h4;

    // ****************************************
    // Link serialiser
    // ****************************************
    localparam int DPSF_LINK_BITS = 32;
    localparam logic [4:0] DPSF_LINK_LAST = 5'h1f;
    localparam logic [4:0] DPSF_CNT_RST = 5'h00;

    typedef enum logic [1:0] {
        DPSF_LINK_IDLE = 2'b01,
        DPSF_LINK_SHIFT = 2'b10
    } dpsf_link_state_t;
endpackage

/* File: rtl/dpsf_sync.sv */
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module dpsf_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

/* File: rtl/dpsf_top.sv */
// Debug port status word with erase acknowledge, interrupts and serial readout link
// Operation
// - Any system reset clears the mass erase acknowledge flag, bit 0.
// - Launching a mass erase also clears the acknowledge flag.
// - Acknowledge sets only once flash control has started the erase.
// - With erase disabled, a request never sets the acknowledge flag.
// - Disabled erase is not performed; in-progress stays set until system reset.
// - Bit 1 shows flash initialised, readable even while system held in reset.
// - Bit 2 shows security lock; secured denies debugger system bus access.
// - Bit 3 reads 0 in system reset, 1 out of reset.
// - Bit 5 reads 1 when mass erase is permitted, 0 otherwise.
// - Bit 6 reads 1 when backdoor key is enabled, 0 otherwise.
// - Bit 7 high when stop mode select is a low power stop mode.
// - Core_sleep_flag without deep sleep means wait; with deep sleep means stop.
// - Bit 8 is a live, non-latching very low power mode indication.
`timescale 1ns/100ps
module dpsf_top
    import dpsf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [dpsf_pkg::DPSF_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // Device state inputs
    input wire logic sys_reset,
    input wire logic flash_init_done,
    input wire logic secured,
    input wire logic erase_enable_setting,
    input wire logic backdoor_key_enable,
    input wire logic [2:0] stop_mode_select_field,
    input wire logic very_low_power_mode,
    input wire logic core_sleep_flag,
    input wire logic core_deep_sleep_flag,
    // Mass erase handshake, bus access and core sleep mode outputs
    input wire logic erase_launch,
    input wire logic flash_erase_started,
    input wire logic flash_erase_done,
    output logic erase_in_progress,
    output logic erase_request,
    output logic bus_access_allow,
    output logic core_wait_mode,
    output logic core_stop_mode,
    // Serial readout link
    input wire logic link_clk,
    input wire logic link_sel_n,
    output logic link_dout,
    output logic link_dout_oe
);
    import dpsf_pkg::*;

    logic erase_ack;
    logic lp_stop;
    logic [31:0] status_word;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [3:0] events;
    logic [3:0] next_irq_stat;
    logic ready_d;
    logic secure_d;
    logic vlp_d;
    logic [1:0] link_sync;
    logic link_clk_d;
    logic link_sel_d;
    logic link_rise;
    logic link_start;
    logic link_stop;
    logic [31:0] shift;
    logic [4:0] bit_cnt;
    dpsf_link_state_t link_state;

    // ****************************************
    // Status word
    // ****************************************
    assign lp_stop = stop_mode_select_field inside
                     {DPSF_STOP_VERY_LOW_POWER_STOP, DPSF_STOP_LLS, DPSF_STOP_VLLS};

    always_comb begin
        status_word = DPSF_RST_WORD;
        status_word[DPSF_B_ERASE_ACK] = erase_ack;
        status_word[DPSF_B_FLASH_RDY] = flash_init_done;
        status_word[DPSF_B_SECURE] = secured;
        status_word[DPSF_B_SYS_OUT_RST] = ~sys_reset;
        status_word[DPSF_B_RSVD] = 1'b0;
        status_word[DPSF_B_ERASE_EN] = erase_enable_setting;
        status_word[DPSF_B_BACKDOOR] = backdoor_key_enable;
        status_word[DPSF_B_LP_STOP] = lp_stop;
        status_word[DPSF_B_VLP_MODE] = very_low_power_mode;
    end

    // No latch: bit 8 must follow the mode so the debugger can retune its clock
    assign bus_access_allow = ~secured;
    assign core_wait_mode = core_sleep_flag & ~core_deep_sleep_flag;
    assign core_stop_mode = core_sleep_flag & core_deep_sleep_flag;

    // ****************************************
    // Mass erase handshake
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            erase_in_progress <= 1'b0;
        end else if (sys_reset) begin
            erase_in_progress <= 1'b0;
        end else if (erase_launch) begin
            erase_in_progress <= 1'b1;
        end else if (flash_erase_done && erase_enable_setting) begin
            erase_in_progress <= 1'b0;
        end
    end

    // Request goes out only when permitted; a refused one is never performed
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            erase_request <= 1'b0;
        end else begin
            erase_request <= erase_launch & erase_enable_setting & ~sys_reset;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            erase_ack <= 1'b0;
        end else if (sys_reset) begin
            erase_ack <= 1'b0;
        end else if (erase_launch) begin
            erase_ack <= 1'b0;
        end else if (flash_erase_started && erase_in_progress && erase_enable_setting) begin
            erase_ack <= 1'b1;
        end
    end

    // ****************************************
    // Register port and interrupts
    // ****************************************
    always_comb begin
        events = 4'h0;
        events[DPSF_I_ACK] = ~sys_reset & ~erase_launch & flash_erase_started
                             & erase_in_progress & erase_enable_setting & ~erase_ack;
        events[DPSF_I_READY] = flash_init_done & ~ready_d;
        events[DPSF_I_SECURE] = secured ^ secure_d;
        events[DPSF_I_VLP] = very_low_power_mode ^ vlp_d;
        next_irq_stat = irq_stat;
        if (reg_wr && reg_addr == DPSF_OFS_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~reg_wdata[3:0];
        end
        // Set wins over a clear in the same cycle
        next_irq_stat = next_irq_stat | events;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_stat <= DPSF_RST_IRQ;
            ready_d <= 1'b0;
            secure_d <= 1'b0;
            vlp_d <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            ready_d <= flash_init_done;
            secure_d <= secured;
            vlp_d <= very_low_power_mode;
        end
    end

    // Writes to the status word fall through here and change nothing
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_mask <= DPSF_RST_IRQ;
        end else if (reg_wr && reg_addr == DPSF_OFS_IRQ_MASK) begin
            irq_mask <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_irq_stat & irq_mask);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                DPSF_OFS_STATUS: reg_rdata <= status_word;
                DPSF_OFS_IRQ_STAT: reg_rdata <= {28'h0000000, irq_stat};
                DPSF_OFS_IRQ_MASK: reg_rdata <= {28'h0000000, irq_mask};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Serial readout link
    // ****************************************
    dpsf_sync #(.WIDTH(2)) u_link_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({link_sel_n, link_clk}),
        .sync_out(link_sync)
    );

    // Reset value of select is low, so a frame is only started after a seen high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link_clk_d <= 1'b0;
            link_sel_d <= 1'b0;
        end else begin
            link_clk_d <= link_sync[0];
            link_sel_d <= link_sync[1];
        end
    end

    assign link_rise = link_sync[0] & ~link_clk_d;
    assign link_start = link_sel_d & ~link_sync[1];
    assign link_stop = link_sync[1];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link_state <= DPSF_LINK_IDLE;
            shift <= DPSF_RST_WORD;
            bit_cnt <= DPSF_CNT_RST;
            link_dout_oe <= 1'b0;
        end else begin
            unique case (link_state)
                DPSF_LINK_IDLE: begin
                    if (link_start) begin
                        link_state <= DPSF_LINK_SHIFT;
                        shift <= status_word;
                        bit_cnt <= DPSF_CNT_RST;
                        link_dout_oe <= 1'b1;
                    end
                end
                DPSF_LINK_SHIFT: begin
                    if (link_stop) begin
                        link_state <= DPSF_LINK_IDLE;
                        link_dout_oe <= 1'b0;
                    end else if (link_rise) begin
                        shift <= {1'b0, shift[31:1]};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == DPSF_LINK_LAST) begin
                            link_state <= DPSF_LINK_IDLE;
                            link_dout_oe <= 1'b0;
                        end
                    end
                end
                default: begin
                    link_state <= DPSF_LINK_IDLE;
                    link_dout_oe <= 1'b0;
                end
            endcase
        end
    end

    assign link_dout = shift[0];

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_launch_ok;
        erase_launch && erase_enable_setting && !sys_reset;
    endsequence
    sequence s_status_read;
        reg_rd && reg_addr == DPSF_OFS_STATUS;
    endsequence
    property p_ack_sysrst;
        @(posedge sys_clk) disable iff (rst) sys_reset |=> !erase_ack;
    endproperty
    a_ack_sysrst: assert property (p_ack_sysrst) else $error("ack survived reset");
    property p_ack_launch;
        @(posedge sys_clk) disable iff (rst) erase_launch |=> !erase_ack;
    endproperty
    a_ack_launch: assert property (p_ack_launch) else $error("ack survived launch");
    property p_ack_started;
        @(posedge sys_clk) disable iff (rst)
            $rose(erase_ack) |-> $past(flash_erase_started) && $past(erase_in_progress);
    endproperty
    a_ack_started: assert property (p_ack_started) else $error("ack without start");
    property p_ack_disabled;
        @(posedge sys_clk) disable iff (rst) $rose(erase_ack) |-> $past(erase_enable_setting);
    endproperty
    a_ack_disabled: assert property (p_ack_disabled) else $error("ack while disabled");
    property p_erase_req;
        @(posedge sys_clk) disable iff (rst)
            s_launch_ok |=> erase_request ##1 (!erase_request || $past(erase_launch));
    endproperty
    a_erase_req: assert property (p_erase_req) else $error("erase request wrong");
    property p_eip_hold;
        @(posedge sys_clk) disable iff (rst)
            erase_in_progress && !erase_enable_setting && !sys_reset |=> erase_in_progress;
    endproperty
    a_eip_hold: assert property (p_eip_hold) else $error("in progress dropped");
    property p_no_req_disabled;
        @(posedge sys_clk) disable iff (rst) erase_request |-> $past(erase_enable_setting);
    endproperty
    a_no_req_disabled: assert property (p_no_req_disabled) else $error("refused erase sent");
    property p_read_fields;
        @(posedge sys_clk) disable iff (rst)
            s_status_read |=> reg_rdata[DPSF_B_FLASH_RDY] == $past(flash_init_done)
                && reg_rdata[DPSF_B_SYS_OUT_RST] == !$past(sys_reset)
                && reg_rdata[DPSF_B_SECURE] == $past(secured);
    endproperty
    a_read_fields: assert property (p_read_fields) else $error("status fields wrong");
    property p_secure_deny;
        @(posedge sys_clk) disable iff (rst) secured |-> !bus_access_allow;
    endproperty
    a_secure_deny: assert property (p_secure_deny) else $error("bus open when secured");
    property p_read_modes;
        @(posedge sys_clk) disable iff (rst)
            s_status_read |=> reg_rdata[DPSF_B_ERASE_EN] == $past(erase_enable_setting)
                && reg_rdata[DPSF_B_BACKDOOR] == $past(backdoor_key_enable)
                && reg_rdata[DPSF_B_LP_STOP] == $past(lp_stop);
    endproperty
    a_read_modes: assert property (p_read_modes) else $error("mode fields wrong");
    property p_sleep_decode;
        @(posedge sys_clk) disable iff (rst)
            core_sleep_flag |-> core_wait_mode == !core_deep_sleep_flag
                && core_stop_mode == core_deep_sleep_flag;
    endproperty
    a_sleep_decode: assert property (p_sleep_decode) else $error("sleep decode wrong");
    property p_vlp_live;
        @(posedge sys_clk) disable iff (rst)
            s_status_read |=> reg_rdata[DPSF_B_VLP_MODE] == $past(very_low_power_mode);
    endproperty
    a_vlp_live: assert property (p_vlp_live) else $error("vlp bit stale");
    property p_rsvd_zero;
        @(posedge sys_clk) disable iff (rst)
            s_status_read |=> !reg_rdata[DPSF_B_RSVD] && reg_rdata[31:9] == 23'h000000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");
endmodule

/* File: tb/dpsf_dbg_model.sv */
// Debugger model that reads the status word over the serial link
`timescale 1ns/100ps
module dpsf_dbg_model (
    output logic link_clk,
    output logic link_sel_n,
    input wire logic link_dout,
    input wire logic link_dout_oe,
    input wire logic core_sleep_flag,
    input wire logic core_deep_sleep_flag
);
    int oe_err;
    logic slow;
    logic very_low_power_stop_seen;
    initial begin
        link_clk = 1'b0;
        link_sel_n = 1'b1;
        oe_err = 0;
        slow = 1'b0;
        very_low_power_stop_seen = 1'b0;
    end
    // Clock stands still outside frames, bits sampled before each rise
    task automatic read_frame(output logic [31:0] w);
        int h;
        h = slow ? 320 : 160;
        // Keep pin edges clear of the sampling clock edge
        #7;
        link_sel_n = 1'b0;
        #320;
        for (int i = 0; i < 32; i++) begin
            if (link_dout_oe !== 1'b1) oe_err++;
            w[i] = link_dout;
            link_clk = 1'b1;
            #h;
            link_clk = 1'b0;
            #h;
        end
        #320;
        if (link_dout_oe !== 1'b0) oe_err++;
        link_sel_n = 1'b1;
        slow = w[8];
        very_low_power_stop_seen = w[7] & core_sleep_flag & core_deep_sleep_flag;
        #320;
    endtask
endmodule

/* File: tb/test_debug_port_status_flags.sv */
// Self-checking bench of the debug port status block
`timescale 1ns/100ps
module test_debug_port_status_flags;
    import dpsf_pkg::*;
    logic sys_clk, rst, reg_wr, reg_rd, irq;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, fw;
    logic sys_reset, flash_init_done, secured, erase_enable_setting;
    logic backdoor_key_enable, very_low_power_mode, core_sleep_flag, core_deep_sleep_flag;
    logic [2:0] stop_mode_select_field;
    logic erase_launch, flash_erase_started, flash_erase_done;
    logic erase_in_progress, erase_request, bus_access_allow, core_wait_mode, core_stop_mode;
    logic link_clk, link_sel_n, link_dout, link_dout_oe;
    int failures, n_checks;

    dpsf_top dut (.*);
    dpsf_dbg_model dbg (.*);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] exp_word(logic a);
        logic [31:0] w;
        w = 32'h0;
        w[DPSF_B_ERASE_ACK] = a;
        w[DPSF_B_FLASH_RDY] = flash_init_done;
        w[DPSF_B_SECURE] = secured;
        w[DPSF_B_SYS_OUT_RST] = !sys_reset;
        w[DPSF_B_ERASE_EN] = erase_enable_setting;
        w[DPSF_B_BACKDOOR] = backdoor_key_enable;
        w[DPSF_B_LP_STOP] = stop_mode_select_field inside
            {DPSF_STOP_VERY_LOW_POWER_STOP, DPSF_STOP_LLS, DPSF_STOP_VLLS};
        w[DPSF_B_VLP_MODE] = very_low_power_mode;
        return w;
    endfunction
    task automatic chk(logic [31:0] g, logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(logic [3:0] a, logic [31:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic pulse(int k);
        @(posedge sys_clk);
        case (k)
            0: erase_launch <= 1'b1;
            1: flash_erase_started <= 1'b1;
            default: flash_erase_done <= 1'b1;
        endcase
        @(posedge sys_clk);
        erase_launch <= 1'b0;
        flash_erase_started <= 1'b0;
        flash_erase_done <= 1'b0;
        #1;
    endtask
    task automatic sys_rst_pulse();
        @(posedge sys_clk);
        sys_reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic close_out();
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Frames dominate the run; this bound is over forty times their total
    initial begin
        #2000000;
        failures++;
        close_out();
    end
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 38'h0};
        {sys_reset, flash_init_done, secured, erase_enable_setting} = 4'h0;
        {backdoor_key_enable, very_low_power_mode} = 2'h0;
        {core_sleep_flag, core_deep_sleep_flag, stop_mode_select_field} = 5'h0;
        {erase_launch, flash_erase_started, flash_erase_done} = 3'h0;
        failures = 0;
        n_checks = 0;
        void'($urandom(32'hd0228983));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk(DPSF_OFS_IRQ_MASK, 32'h0);
        chk(32'(link_dout_oe), 32'h0);
        rdchk(4'hc, 32'h0);
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            {sys_reset, flash_init_done, secured, erase_enable_setting} <= 4'($urandom);
            {backdoor_key_enable, very_low_power_mode} <= 2'($urandom);
            {core_sleep_flag, core_deep_sleep_flag} <= 2'($urandom);
            stop_mode_select_field <= 3'(i);
            repeat (3) @(posedge sys_clk);
            #1;
            chk(32'(bus_access_allow), 32'(!secured));
            chk(32'({core_wait_mode, core_stop_mode}), 32'({core_sleep_flag &
                !core_deep_sleep_flag, core_sleep_flag & core_deep_sleep_flag}));
            if (i == 5) wr(DPSF_OFS_STATUS, 32'hffff_ffff);
            rdchk(DPSF_OFS_STATUS, exp_word(1'b0));
            chk(32'(irq), 32'h0);
        end
        // Masked event, then unmasked, then cleared by writing one
        @(posedge sys_clk);
        {sys_reset, very_low_power_mode, erase_enable_setting} <= 3'b001;
        repeat (3) @(posedge sys_clk);
        wr(DPSF_OFS_IRQ_STAT, 32'hf);
        very_low_power_mode <= 1'b1;
        rdchk(DPSF_OFS_IRQ_STAT, 32'h8);
        chk(32'(irq), 32'h0);
        wr(DPSF_OFS_IRQ_MASK, 32'h8);
        @(posedge sys_clk);
        #1;
        chk(32'(irq), 32'h1);
        wr(DPSF_OFS_IRQ_STAT, 32'h8);
        @(posedge sys_clk);
        #1;
        chk(32'(irq), 32'h0);
        wr(DPSF_OFS_IRQ_MASK, 32'h1);
        // Permitted erase: request, acknowledge, relaunch, system reset
        pulse(0);
        chk(32'({erase_in_progress, erase_request}), 32'h3);
        @(posedge sys_clk);
        #1;
        chk(32'(erase_request), 32'h0);
        rdchk(DPSF_OFS_STATUS, exp_word(1'b0));
        pulse(1);
        rdchk(DPSF_OFS_STATUS, exp_word(1'b1));
        chk(32'(irq), 32'h1);
        pulse(2);
        chk(32'(erase_in_progress), 32'h0);
        pulse(0);
        rdchk(DPSF_OFS_STATUS, exp_word(1'b0));
        pulse(1);
        pulse(2);
        sys_rst_pulse();
        rdchk(DPSF_OFS_STATUS, exp_word(1'b0));
        // Disabled erase: no request, no acknowledge, stays in progress
        @(posedge sys_clk);
        erase_enable_setting <= 1'b0;
        pulse(0);
        chk(32'({erase_in_progress, erase_request}), 32'h2);
        pulse(1);
        rdchk(DPSF_OFS_STATUS, exp_word(1'b0));
        pulse(2);
        chk(32'(erase_in_progress), 32'h1);
        sys_rst_pulse();
        chk(32'(erase_in_progress), 32'h0);
        // Link frames: fast, fast with the mode bit one, then slowed once a frame has read it as one
        @(posedge sys_clk);
        very_low_power_mode <= 1'b0;
        repeat (3) @(posedge sys_clk);
        dbg.read_frame(fw);
        chk(fw, exp_word(1'b0));
        @(posedge sys_clk);
        {very_low_power_mode, stop_mode_select_field} <= 4'hb;
        repeat (3) @(posedge sys_clk);
        dbg.read_frame(fw);
        chk(fw, exp_word(1'b0));
        @(posedge sys_clk);
        {core_sleep_flag, core_deep_sleep_flag, stop_mode_select_field} <= 5'h1a;
        repeat (3) @(posedge sys_clk);
        dbg.read_frame(fw);
        chk(fw, exp_word(1'b0));
        chk(32'(dbg.very_low_power_stop_seen), 32'h1);
        chk(32'(dbg.oe_err), 32'h0);
        close_out();
    end
endmodule
